// file: src/pin_state_pkg.sv
// shared constants and types for the pin state controller
package pin_state_pkg;
  // processor condition that decides how pins are driven
  typedef enum logic [2:0] {
    COND_RUN,
    COND_POWER_ON,
    COND_MANUAL,
    COND_STANDBY,
    COND_HW_STANDBY,
    COND_SLEEP,
    COND_RELEASED
  } cond_type;

  localparam int STRAP_W        = 6;   // six mode strap pins
  localparam int CLK_MODE_W     = 3;   // three low straps pick the clock mode
  localparam int PORT_W         = 8;   // data bits 23..16 as port
  localparam int TOP_W          = 2;   // data bits 31..30
  localparam int STROBE_W       = 5;   // row strobe plus four column strobes
  localparam int CTRL_W         = 13;  // chip selects, start, byte writes, read/write
  localparam int SYNC_STAGES    = 3;   // pin input synchroniser depth
  // clock modes in which the system clock pin is an input
  localparam logic [2:0] CLK_MODE_IN_A = 3'h5;
  localparam logic [2:0] CLK_MODE_IN_B = 3'h6;
  localparam logic [5:0] STRAP_RESET   = 6'h00;
endpackage

// file: src/pin_in_sync.sv
// three-stage synchroniser with agreement filter for one pin input
module pin_in_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      level
);
  logic s1_r;  // metastable stage, read only by s2
  logic s2_r;
  logic s3_r;

  // shift chain
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // change counts only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!resetn) begin
      level <= RESET_VAL;
    end else if (s2_r == s3_r) begin
      level <= s3_r;
    end
  end
endmodule

// file: src/pin_drive_cell.sv
// one pin driver: selects output level and enable per drive option
module pin_drive_cell (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic as_input,   // pin is an input, not driven
  input  wire logic float_pin,  // pin at high impedance
  input  wire logic force_high, // pin driven high
  input  wire logic force_low,  // pin driven low
  input  wire logic keep,       // hold last driven level
  input  wire logic func_out,   // functional output value
  output logic      pin_out,
  output logic      pin_oe_n
);
  logic last_r;  // last level actually driven

  // register the pin so strobes change only on clock edges
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b1;
      last_r   <= 1'b1;
    end else begin
      if (as_input || float_pin) begin
        pin_oe_n <= 1'b1;
        pin_out  <= last_r;
      end else if (force_high) begin
        pin_oe_n <= 1'b0;
        pin_out  <= 1'b1;
        last_r   <= 1'b1;
      end else if (force_low) begin
        pin_oe_n <= 1'b0;
        pin_out  <= 1'b0;
        last_r   <= 1'b0;
      end else if (keep) begin
        // output held at its last level, no new value taken
        pin_oe_n <= 1'b0;
        pin_out  <= last_r;
      end else begin
        pin_oe_n <= 1'b0;
        pin_out  <= func_out;
        last_r   <= func_out;
      end
    end
  end
endmodule

// file: src/pin_state_control.sv
// pin drive selection across resets, power-down and bus release
// Function
// R1: clock pin direction follows strap clock mode
// R2: serial clock pin input unless used, then register
// R3: serial transmit pin input unless used, then output
// R4: card enables input, else high or float
// R5: second row strobe output when area2 DRAM used
// R6: standby/release: row strobe float or output by register
// R7: standby card enables float or high by register
// R8: top data bits float unless used as port
// R9: port data bits float or keep by register
// R10: keep mode floats inputs, holds outputs
// R11: strobes float or drive by register, high at reset
// R12: bus controls float, high or driven per state
// R13: timer clock direction by state and register
// R14: every pin has a defined state per condition
// R15: straps latched at power-on, function needs enable
// R16: all drive changes registered, glitch free
module pin_state_control
  import pin_state_pkg::*;
(
  input  wire logic                                 clock,
  input  wire logic                                 resetn,
  input  wire pin_state_pkg::cond_type              condition,
  input  wire logic                                 serial_enable,
  input  wire logic                                 port_enable,
  input  wire logic                                 serial_clock_output_sel,
  input  wire logic                                 card_enable,
  input  wire logic                                 card_float_sel,
  input  wire logic                                 area2_dram_enable,
  input  wire logic                                 strobe_float_sel,
  input  wire logic                                 ctrl_float_sel,
  input  wire logic                                 port_keep_sel,
  input  wire logic                                 timer_clock_output_sel,
  input  wire logic                                 serial_clock_value,
  input  wire logic                                 serial_tx_value,
  input  wire logic [1:0]                           card_enable_value,
  input  wire logic                                 second_row_strobe_value,
  input  wire logic [pin_state_pkg::STROBE_W-1:0]   strobe_value,
  input  wire logic [pin_state_pkg::CTRL_W-1:0]     ctrl_value,
  input  wire logic [pin_state_pkg::TOP_W-1:0]      top_data_value,
  input  wire logic [pin_state_pkg::PORT_W-1:0]     port_value,
  input  wire logic [pin_state_pkg::PORT_W-1:0]     port_dir_out,
  input  wire logic                                 timer_clock_value,
  input  wire logic                                 system_clock_value,
  input  wire logic [pin_state_pkg::STRAP_W-1:0]    strap_pin_in,
  output logic [pin_state_pkg::STRAP_W-1:0]         strap_latched,
  output logic [pin_state_pkg::CLK_MODE_W-1:0]      clock_mode_straps,
  output logic                                      system_clock_pin_out,
  output logic                                      system_clock_pin_oe_n,
  output logic                                      strap0_serial_clock_pin_out,
  output logic                                      strap0_serial_clock_pin_oe_n,
  output logic                                      strap1_serial_transmit_pin_out,
  output logic                                      strap1_serial_transmit_pin_oe_n,
  output logic                                      strap3_card_enable_a_pin_out,
  output logic                                      strap3_card_enable_a_pin_oe_n,
  output logic                                      strap4_card_enable_b_pin_out,
  output logic                                      strap4_card_enable_b_pin_oe_n,
  output logic                                      strap5_second_row_strobe_pin_out,
  output logic                                      strap5_second_row_strobe_pin_oe_n,
  output logic [pin_state_pkg::STROBE_W-1:0]        strobe_pin_out,
  output logic [pin_state_pkg::STROBE_W-1:0]        strobe_pin_oe_n,
  output logic [pin_state_pkg::CTRL_W-1:0]          ctrl_pin_out,
  output logic [pin_state_pkg::CTRL_W-1:0]          ctrl_pin_oe_n,
  output logic [pin_state_pkg::TOP_W-1:0]           top_data_pin_out,
  output logic [pin_state_pkg::TOP_W-1:0]           top_data_pin_oe_n,
  output logic [pin_state_pkg::PORT_W-1:0]          port_pin_out,
  output logic [pin_state_pkg::PORT_W-1:0]          port_pin_oe_n,
  output logic                                      timer_clock_pin_out,
  output logic                                      timer_clock_pin_oe_n
);
  import pin_state_pkg::*;

  logic [STRAP_W-1:0] strap_sync;   // filtered strap levels
  logic               por_seen_r;   // strap capture done
  logic               in_por;       // power-on reset condition
  logic               in_manual;
  logic               in_standby;   // software or hardware standby
  logic               in_hw_stby;
  logic               in_sleep;
  logic               in_release;
  logic               clk_is_input; // clock mode makes clock pin an input

  // synchronise each strap pin with the agreement filter
  genvar gi;
  for (gi = 0; gi < STRAP_W; gi++) begin : g_strap_sync
    pin_in_sync #(.RESET_VAL(1'b0)) u_sync (
      .clock  (clock),
      .resetn (resetn),
      .pin_in (strap_pin_in[gi]),
      .level  (strap_sync[gi])
    );
  end

  // condition decode
  always_comb begin
    in_por     = (condition == COND_POWER_ON);
    in_manual  = (condition == COND_MANUAL);
    in_hw_stby = (condition == COND_HW_STANDBY);
    in_standby = (condition == COND_STANDBY) || in_hw_stby;
    in_sleep   = (condition == COND_SLEEP);
    in_release = (condition == COND_RELEASED);
  end

  // straps follow the pins during power-on reset and freeze after it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      strap_latched <= STRAP_RESET;
      por_seen_r    <= 1'b0;
    end else if (in_por) begin
      strap_latched <= strap_sync; // [R15]
      por_seen_r    <= 1'b1;
    end
  end

  assign clock_mode_straps = strap_latched[CLK_MODE_W-1:0];
  // only some clock modes take the clock in from outside
  assign clk_is_input = (clock_mode_straps == CLK_MODE_IN_A) ||
                        (clock_mode_straps == CLK_MODE_IN_B);

  // per-pin drive option vectors; strap pins are inputs until enabled
  logic sck_in, sck_hi;
  logic txd_in;
  logic card_in, card_z, card_hi;
  logic ras2_in, ras2_z;
  logic strb_z, strb_hi;
  logic ctl_z, ctl_hi;
  logic top_z;
  logic port_z, port_keep;
  logic timer_clock_pin_in, timer_clock_pin_z, timer_clock_pin_lo;
  logic sys_in;

  always_comb begin
    // clock pin direction by strap mode in every condition
    sys_in  = clk_is_input; // [R1]
    // serial clock: input unless sleep/release with function in use and output selected
    sck_in  = !((in_sleep || in_release) && (serial_enable || port_enable) &&
                serial_clock_output_sel); // [R2]
    sck_hi  = 1'b0;
    // serial transmit: driven only in sleep/release when used
    txd_in  = !((in_sleep || in_release) &&
                (serial_enable || port_enable)); // [R3]
    // card enables
    card_in = !card_enable || in_por || !por_seen_r; // [R4] [R15]
    card_hi = 1'b0;
    card_z  = 1'b0;
    if (in_manual || in_sleep) begin
      card_hi = 1'b1; // [R4]
    end else if (in_release) begin
      card_z  = 1'b1; // [R4]
    end else if (in_standby) begin
      card_z  = card_float_sel;  // [R7]
      card_hi = !card_float_sel; // [R7]
    end
    // second row strobe
    ras2_in = !area2_dram_enable || in_por || !por_seen_r; // [R5] [R15]
    ras2_z  = (in_standby || in_release) && strobe_float_sel; // [R6]
    // row and column strobes
    strb_hi = in_por; // [R11]
    strb_z  = (in_standby || in_release) && strobe_float_sel; // [R11]
    // chip selects, start, byte writes, read/write
    ctl_hi  = in_por || in_sleep || (in_standby && !ctrl_float_sel); // [R12]
    ctl_z   = in_release || (in_standby && ctrl_float_sel);         // [R12]
    // top data bits float except when used as port
    top_z   = in_por || !port_enable; // [R8]
    // port bits float; keep mode by register when used as port
    port_z    = in_por || !port_enable || in_release || in_standby ||
                in_manual || in_sleep; // [R9]
    port_keep = port_enable && port_keep_sel && !in_por &&
                (condition != COND_RUN); // [R9]
    // timer clock
    timer_clock_pin_z  = in_por || in_manual; // [R13]
    timer_clock_pin_in = !timer_clock_pin_z && !in_hw_stby && !timer_clock_output_sel; // [R13]
    timer_clock_pin_lo = in_hw_stby && timer_clock_output_sel; // [R13]
    if (in_hw_stby && !timer_clock_output_sel) begin
      timer_clock_pin_in = 1'b1;
    end
  end

  // every pin passes a registered drive cell so no strobe glitches [R16] [R14]
  pin_drive_cell u_sys (
    .clock(clock), .resetn(resetn), .as_input(sys_in), .float_pin(1'b0),
    .force_high(1'b0), .force_low(1'b0), .keep(1'b0), .func_out(system_clock_value),
    .pin_out(system_clock_pin_out), .pin_oe_n(system_clock_pin_oe_n));
  pin_drive_cell u_sck (
    .clock(clock), .resetn(resetn), .as_input(sck_in), .float_pin(1'b0),
    .force_high(sck_hi), .force_low(1'b0), .keep(1'b0), .func_out(serial_clock_value),
    .pin_out(strap0_serial_clock_pin_out), .pin_oe_n(strap0_serial_clock_pin_oe_n));
  pin_drive_cell u_txd (
    .clock(clock), .resetn(resetn), .as_input(txd_in), .float_pin(1'b0),
    .force_high(1'b0), .force_low(1'b0), .keep(1'b0), .func_out(serial_tx_value),
    .pin_out(strap1_serial_transmit_pin_out), .pin_oe_n(strap1_serial_transmit_pin_oe_n));
  pin_drive_cell u_cea (
    .clock(clock), .resetn(resetn), .as_input(card_in), .float_pin(card_z),
    .force_high(card_hi), .force_low(1'b0), .keep(1'b0), .func_out(card_enable_value[0]),
    .pin_out(strap3_card_enable_a_pin_out), .pin_oe_n(strap3_card_enable_a_pin_oe_n));
  pin_drive_cell u_ceb (
    .clock(clock), .resetn(resetn), .as_input(card_in), .float_pin(card_z),
    .force_high(card_hi), .force_low(1'b0), .keep(1'b0), .func_out(card_enable_value[1]),
    .pin_out(strap4_card_enable_b_pin_out), .pin_oe_n(strap4_card_enable_b_pin_oe_n));
  pin_drive_cell u_ras2 (
    .clock(clock), .resetn(resetn), .as_input(ras2_in), .float_pin(ras2_z),
    .force_high(1'b0), .force_low(1'b0), .keep(1'b0),
    .func_out(second_row_strobe_value),
    .pin_out(strap5_second_row_strobe_pin_out),
    .pin_oe_n(strap5_second_row_strobe_pin_oe_n));
  pin_drive_cell u_timer_clock_pin (
    .clock(clock), .resetn(resetn), .as_input(timer_clock_pin_in), .float_pin(timer_clock_pin_z),
    .force_high(1'b0), .force_low(timer_clock_pin_lo), .keep(1'b0), .func_out(timer_clock_value),
    .pin_out(timer_clock_pin_out), .pin_oe_n(timer_clock_pin_oe_n));

  // row and column strobes
  for (gi = 0; gi < STROBE_W; gi++) begin : g_strobe
    pin_drive_cell u_cell (
      .clock(clock), .resetn(resetn), .as_input(1'b0), .float_pin(strb_z),
      .force_high(strb_hi), .force_low(1'b0), .keep(1'b0), .func_out(strobe_value[gi]),
      .pin_out(strobe_pin_out[gi]), .pin_oe_n(strobe_pin_oe_n[gi])); // [R11]
  end

  // bus control outputs
  for (gi = 0; gi < CTRL_W; gi++) begin : g_ctrl
    pin_drive_cell u_cell (
      .clock(clock), .resetn(resetn), .as_input(1'b0), .float_pin(ctl_z),
      .force_high(ctl_hi), .force_low(1'b0), .keep(1'b0), .func_out(ctrl_value[gi]),
      .pin_out(ctrl_pin_out[gi]), .pin_oe_n(ctrl_pin_oe_n[gi])); // [R12]
  end

  // top data bits as general port
  for (gi = 0; gi < TOP_W; gi++) begin : g_top
    pin_drive_cell u_cell (
      .clock(clock), .resetn(resetn), .as_input(1'b0), .float_pin(top_z),
      .force_high(1'b0), .force_low(1'b0), .keep(1'b0), .func_out(top_data_value[gi]),
      .pin_out(top_data_pin_out[gi]), .pin_oe_n(top_data_pin_oe_n[gi])); // [R8]
  end

  // port bits: keep floats inputs and holds outputs
  for (gi = 0; gi < PORT_W; gi++) begin : g_port
    pin_drive_cell u_cell (
      .clock(clock), .resetn(resetn),
      .as_input(!port_dir_out[gi] && port_enable && !in_por), // [R10]
      .float_pin(port_z && !(port_keep && port_dir_out[gi])), // [R10]
      .force_high(1'b0), .force_low(1'b0),
      .keep(port_keep && port_dir_out[gi]), // [R10]
      .func_out(port_value[gi]),
      .pin_out(port_pin_out[gi]), .pin_oe_n(port_pin_oe_n[gi]));
  end
endmodule

// file: tb/pin_state_checker.sv
// concurrent checks on the pin state controller ports
module pin_state_checker
  import pin_state_pkg::*;
(
  input wire logic                                   clock,
  input wire logic                                   resetn,
  input wire pin_state_pkg::cond_type                condition,
  input wire logic                                   serial_enable,
  input wire logic                                   port_enable,
  input wire logic                                   port_keep_sel,
  input wire logic                                   timer_clock_output_sel,
  input wire logic [pin_state_pkg::PORT_W-1:0]       port_dir_out,
  input wire logic [pin_state_pkg::STRAP_W-1:0]      strap_pin_in,
  input wire logic [pin_state_pkg::CLK_MODE_W-1:0]   clock_mode_straps,
  input wire logic [pin_state_pkg::CTRL_W-1:0]       ctrl_pin_out,
  input wire logic [pin_state_pkg::CTRL_W-1:0]       ctrl_pin_oe_n,
  input wire logic [pin_state_pkg::STROBE_W-1:0]     strobe_pin_out,
  input wire logic [pin_state_pkg::STROBE_W-1:0]     strobe_pin_oe_n,
  input wire logic [pin_state_pkg::TOP_W-1:0]        top_data_pin_oe_n,
  input wire logic                                   strap1_serial_transmit_pin_oe_n,
  input wire logic [pin_state_pkg::PORT_W-1:0]       port_pin_out,
  input wire logic [pin_state_pkg::PORT_W-1:0]       port_pin_oe_n,
  input wire logic                                   timer_clock_pin_out,
  input wire logic                                   timer_clock_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // conditions past power-on reset that the pin table covers
  logic after_por;
  assign after_por = condition inside {COND_MANUAL, COND_STANDBY, COND_SLEEP, COND_RELEASED};
  chk_ctrl_sleep_high:
    assert property (condition == COND_SLEEP |=> ctrl_pin_oe_n == '0 && ctrl_pin_out == '1)
    else $error("bus controls not driven high in sleep");
  chk_ctrl_release_float:
    assert property (condition == COND_RELEASED |=> &ctrl_pin_oe_n)
    else $error("bus controls driven while bus released");
  chk_strobe_por_high:
    assert property (condition == COND_POWER_ON |=> strobe_pin_oe_n == '0 && &strobe_pin_out)
    else $error("strobes not high in power-on reset");
  chk_top_data_float:
    assert property (after_por && !port_enable |=> &top_data_pin_oe_n)
    else $error("top data bits driven without port use");
  chk_tx_unused_input:
    assert property (condition inside {COND_SLEEP, COND_RELEASED} && !serial_enable
                     && !port_enable |=> strap1_serial_transmit_pin_oe_n)
    else $error("transmit pin driven while unused");
  chk_timer_hw_low:
    assert property (condition == COND_HW_STANDBY && timer_clock_output_sel
                     |=> !timer_clock_pin_oe_n && !timer_clock_pin_out)
    else $error("timer pin not low in hardware standby");
  // two keep cycles in a row, so the earlier output is already a kept one
  chk_keep_holds:
    assert property ((after_por && port_enable && port_keep_sel && $stable(port_dir_out))[*2]
                     |=> port_pin_oe_n == ~$past(port_dir_out)
                     && ((port_pin_out ^ $past(port_pin_out)) & ~port_pin_oe_n) == '0)
    else $error("keep mode did not hold port outputs");
  // sync plus filter settle well inside eight cycles
  chk_strap_capture:
    assert property ((condition == COND_POWER_ON && $stable(strap_pin_in))[*8]
                     |=> clock_mode_straps == strap_pin_in[2:0])
    else $error("clock mode straps not captured in power-on reset");
endmodule

// file: tb/far_side_model.sv
// far side of the strap pins: strap resistors seen when the device lets go
module far_side_model #(
  parameter logic [5:0] STRAP_VALUE = 6'h2D  // strap levels fitted on the board
) (
  input  wire logic [5:0] pin_out,   // device levels on the strap pins
  input  wire logic [5:0] pin_oe_n,  // device enables, low while driving
  output logic      [5:0] pin_level  // resolved wire levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the device level, a released one its resistor
  assign pin_level = (pin_out & ~pin_oe_n) | (STRAP_VALUE & pin_oe_n);
endmodule

// file: tb/test_pin_state_control.sv
// self-checking bench for the pin state controller
module test_pin_state_control;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_state_pkg::*;
  typedef enum int {CTRL_OE, CTRL_OUT, STB_OE, STB_OUT, TOP_OE, TOP_OUT, PORT_OE, PORT_KEPT,
    CARD_OE, CARD_OUT, ROW2_OE, ROW2_OUT, TX_OE, TX_OUT, SCK_OE, TMR_OE, TMR_OUT, CLK_OE,
    MODE} sig_type;
  typedef struct {int due; sig_type code; logic [15:0] exp;} note_type;
  localparam logic [5:0] STRAPS = 6'h2D;  // board straps, low three pick clock mode
  // enable vector bits, serial enable at the top down to timer output select
  localparam logic [9:0] SER = 10'h200, PRT = 10'h100, SCKO = 10'h080, CRD = 10'h040;
  localparam logic [9:0] CFL = 10'h020, A2 = 10'h010, SFL = 10'h008, CTF = 10'h004;
  localparam logic [9:0] KP = 10'h002, TMO = 10'h001;
  logic                  clock = 1'b0;
  logic                  resetn = 1'b0;
  cond_type              condition = COND_RUN;
  logic [9:0]            en = '0;           // function enables and selects
  logic [63:0]           val = '0;          // functional output values
  logic [63:0]           nv;                // values of the latest step
  logic [31:0]           seed = 32'hECE293B2;
  logic [7:0]            kept;              // port level expected to be held
  logic [STRAP_W-1:0]    strap_latched, strap_pin_in;
  logic [CLK_MODE_W-1:0] clock_mode_straps;
  logic system_clock_pin_out, system_clock_pin_oe_n, timer_clock_pin_out, timer_clock_pin_oe_n;
  logic strap0_serial_clock_pin_out, strap0_serial_clock_pin_oe_n;
  logic strap1_serial_transmit_pin_out, strap1_serial_transmit_pin_oe_n;
  logic strap3_card_enable_a_pin_out, strap3_card_enable_a_pin_oe_n;
  logic strap4_card_enable_b_pin_out, strap4_card_enable_b_pin_oe_n;
  logic strap5_second_row_strobe_pin_out, strap5_second_row_strobe_pin_oe_n;
  logic [STROBE_W-1:0]   strobe_pin_out, strobe_pin_oe_n;
  logic [CTRL_W-1:0]     ctrl_pin_out, ctrl_pin_oe_n;
  logic [TOP_W-1:0]      top_data_pin_out, top_data_pin_oe_n;
  logic [PORT_W-1:0]     port_pin_out, port_pin_oe_n, port_dir_out = '0;
  int                    cyc = 0;           // falling edges seen
  int                    n_mismatch = 0;
  int                    n_tests = 0;
  note_type              notes[$];          // expected results, oldest first
  pin_state_control dut_u (.serial_enable(en[9]), .port_enable(en[8]),
    .serial_clock_output_sel(en[7]), .card_enable(en[6]), .card_float_sel(en[5]),
    .area2_dram_enable(en[4]), .strobe_float_sel(en[3]), .ctrl_float_sel(en[2]),
    .port_keep_sel(en[1]), .timer_clock_output_sel(en[0]), .serial_clock_value(val[0]),
    .serial_tx_value(val[1]), .card_enable_value(val[3:2]), .second_row_strobe_value(val[4]),
    .strobe_value(val[9:5]), .ctrl_value(val[22:10]), .top_data_value(val[24:23]),
    .port_value(val[32:25]), .timer_clock_value(val[33]), .system_clock_value(val[34]), .*);
  // strap pin 2 is input only, so the device never drives it
  far_side_model #(.STRAP_VALUE(STRAPS)) far_u (
    .pin_out({strap5_second_row_strobe_pin_out, strap4_card_enable_b_pin_out,
      strap3_card_enable_a_pin_out, 1'b0, strap1_serial_transmit_pin_out,
      strap0_serial_clock_pin_out}),
    .pin_oe_n({strap5_second_row_strobe_pin_oe_n, strap4_card_enable_b_pin_oe_n,
      strap3_card_enable_a_pin_oe_n, 1'b1, strap1_serial_transmit_pin_oe_n,
      strap0_serial_clock_pin_oe_n}),
    .pin_level(strap_pin_in));
  // clock at 125 MHz
  initial begin
    forever #4 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // observed group value; port outputs only where driven
  function automatic logic [15:0] obs(input sig_type s);
    case (s)
      CTRL_OE:   return 16'(ctrl_pin_oe_n);
      CTRL_OUT:  return 16'(ctrl_pin_out);
      STB_OE:    return 16'(strobe_pin_oe_n);
      STB_OUT:   return 16'(strobe_pin_out);
      TOP_OE:    return 16'(top_data_pin_oe_n);
      TOP_OUT:   return 16'(top_data_pin_out);
      PORT_OE:   return 16'(port_pin_oe_n);
      PORT_KEPT: return 16'(port_pin_out & ~port_pin_oe_n);
      CARD_OE:   return 16'({strap4_card_enable_b_pin_oe_n, strap3_card_enable_a_pin_oe_n});
      CARD_OUT:  return 16'({strap4_card_enable_b_pin_out, strap3_card_enable_a_pin_out});
      ROW2_OE:   return 16'(strap5_second_row_strobe_pin_oe_n);
      ROW2_OUT:  return 16'(strap5_second_row_strobe_pin_out);
      TX_OE:     return 16'(strap1_serial_transmit_pin_oe_n);
      TX_OUT:    return 16'(strap1_serial_transmit_pin_out);
      SCK_OE:    return 16'(strap0_serial_clock_pin_oe_n);
      TMR_OE:    return 16'(timer_clock_pin_oe_n);
      TMR_OUT:   return 16'(timer_clock_pin_out);
      CLK_OE:    return 16'(system_clock_pin_oe_n);
      default:   return 16'(clock_mode_straps);
    endcase
  endfunction
  task automatic check(input sig_type s, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", s.name(), exp, seen);
    end
  endtask
  // one step: new condition, enables and random values after a rising edge
  task automatic apply(input cond_type c, input logic [9:0] e, input logic [7:0] d);
    @(posedge clock);
    seed = xs(seed);
    nv[31:0] = seed;
    seed = xs(seed);
    nv[63:32] = seed;
    condition <= c;
    en <= e;
    port_dir_out <= d;
    val <= nv;
  endtask
  // step inputs are taken at the next edge and the pins answer there, two falling edges on
  task automatic note(input sig_type s, input logic [15:0] e);
    notes.push_back('{cyc + 2, s, e});
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // monitor: compares due notes on the falling edge, when outputs have settled
  always @(negedge clock) begin
    note_type n;
    cyc++;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      check(n.code, obs(n.code), n.exp);
    end
  end
  // watchdog, far beyond the few dozen steps of the sequence
  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    static cond_type st[4] = '{COND_MANUAL, COND_STANDBY, COND_SLEEP, COND_RELEASED};
    repeat (4) @(posedge clock);
    note(CTRL_OE, 16'h1FFF);
    @(posedge clock);
    resetn <= 1'b1;
    apply(COND_RUN, CRD | A2, 8'h00);
    note(CARD_OE, 16'h3);
    note(ROW2_OE, 16'h1);
    for (int i = 0; i < 10; i++) apply(COND_POWER_ON, CRD | A2 | SER, 8'h00);
    note(CTRL_OE, 16'h0);
    note(CTRL_OUT, 16'h1FFF);
    note(STB_OE, 16'h0);
    note(STB_OUT, 16'h1F);
    note(TOP_OE, 16'h3);
    note(PORT_OE, 16'hFF);
    note(CARD_OE, 16'h3);
    note(MODE, 16'(STRAPS[2:0]));
    note(CLK_OE, 16'h1);
    foreach (st[i]) begin
      apply(st[i], '0, 8'h00);
      note(CARD_OE, 16'h3);
      note(ROW2_OE, 16'h1);
      note(TX_OE, 16'h1);
      note(SCK_OE, 16'h1);
      note(TOP_OE, 16'h3);
      note(PORT_OE, 16'hFF);
    end
    apply(COND_SLEEP, SER | SCKO, 8'h00);
    note(TX_OE, 16'h0);
    note(TX_OUT, 16'(nv[1]));
    note(SCK_OE, 16'h0);
    note(CTRL_OUT, 16'h1FFF);
    apply(COND_RELEASED, SER, 8'h00);
    note(SCK_OE, 16'h1);
    note(CTRL_OE, 16'h1FFF);
    apply(COND_MANUAL, A2, 8'h00);
    note(ROW2_OE, 16'h0);
    note(ROW2_OUT, 16'(nv[4]));
    apply(COND_STANDBY, A2 | CRD | CFL | SFL | CTF | TMO, 8'h00);
    note(ROW2_OE, 16'h1);
    note(CARD_OE, 16'h3);
    note(STB_OE, 16'h1F);
    note(CTRL_OE, 16'h1FFF);
    note(TMR_OE, 16'h0);
    note(TMR_OUT, 16'(nv[33]));
    apply(COND_STANDBY, A2 | CRD, 8'h00);
    note(ROW2_OE, 16'h0);
    note(CARD_OUT, 16'h3);
    note(STB_OUT, 16'(nv[9:5]));
    note(CTRL_OE, 16'h0);
    note(CTRL_OUT, 16'h1FFF);
    note(TMR_OE, 16'h1);
    apply(COND_HW_STANDBY, TMO, 8'h00);
    note(TMR_OE, 16'h0);
    note(TMR_OUT, 16'h0);
    apply(COND_RELEASED, '0, 8'h00);
    note(STB_OE, 16'h0);
    note(STB_OUT, 16'(nv[9:5]));
    apply(COND_SLEEP, PRT, 8'hF0);
    note(PORT_OE, 16'hFF);
    note(TOP_OE, 16'h0);
    note(TOP_OUT, 16'(nv[24:23]));
    // drive the port, then keep with changed values
    apply(COND_RUN, PRT, 8'hF0);
    kept = nv[32:25];
    apply(COND_SLEEP, PRT | KP, 8'hF0);
    apply(COND_SLEEP, PRT | KP, 8'hF0);
    note(PORT_OE, 16'h0F);
    note(PORT_KEPT, 16'(kept & 8'hF0));
    apply(COND_RUN, '0, 8'h00);
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule
bind pin_state_control pin_state_checker chk_u (.*);
